// ---- logic/pdar_pkg.sv ----
package pdar_pkg;

    // ==========================================================
    // bus and region
    localparam int          PDAR_ADDR_W     = 15;
    localparam int          PDAR_DATA_W     = 32;
    localparam int          PDAR_BE_W       = 4;
    localparam logic        PDAR_BAR_APP    = 1'b1;

    // ==========================================================
    // register byte offsets inside the application region
    localparam logic [14:0] PDAR_OFF_CTRL   = 15'h0000;
    localparam logic [14:0] PDAR_OFF_RELOAD = 15'h0004;
    localparam logic [14:0] PDAR_OFF_COUNT  = 15'h0008;
    localparam logic [14:0] PDAR_OFF_DIP    = 15'h000C;
    localparam logic [14:0] PDAR_OFF_LED    = 15'h0010;

    // ==========================================================
    // memory window
    localparam logic [14:0] PDAR_MEM_BASE   = 15'h1000;
    localparam logic [14:0] PDAR_MEM_END    = 15'h5000;
    localparam int          PDAR_MEM_WORDS  = 4096;
    localparam int          PDAR_IDX_W      = 12;
    localparam int          PDAR_IDX_LSB    = 2;

    // ==========================================================
    // fields and reset values
    localparam int          PDAR_RUN_BIT    = 0;
    localparam int          PDAR_CNT_W      = 32;
    localparam int          PDAR_DIP_W      = 8;
    localparam int          PDAR_LED_W      = 16;
    localparam logic [31:0] PDAR_RELOAD_RST = 32'h0000_0000;
    localparam logic [15:0] PDAR_LED_RST    = 16'h0000;

    // byte-lane merge used by the reload, led and memory writes
    function automatic logic [31:0] pdar_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return res;
    endfunction

endpackage

// ---- logic/pdar_down_counter.sv ----
`timescale 1ns/1ps
module pdar_down_counter
    import pdar_pkg::*;
#(
    parameter int CNT_W = PDAR_CNT_W
)(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] reload,
    output logic      [CNT_W-1:0] count
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } pdar_cnt_s;

    pdar_cnt_s cur;
    pdar_cnt_s next_cur;

    // ==========================================================
    // count logic
    always_comb
    begin
        next_cur = cur;
        if (load)
        begin
            next_cur.count = reload;
        end
        else if (run)
        begin
            if (cur.count == '0)
            begin
                next_cur.count = reload;
            end
            else
            begin
                next_cur.count = cur.count - 1'b1;
            end
        end
    end

    // one clock for the whole block, the core clock in the system
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign count = cur.count;

endmodule

// ---- logic/pdar_block_mem.sv ----
`timescale 1ns/1ps
module pdar_block_mem
    import pdar_pkg::*;
#(
    parameter int WORDS = PDAR_MEM_WORDS,
    parameter int IDX_W = PDAR_IDX_W
)(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             wr_en,
    input  wire logic [IDX_W-1:0] idx,
    input  wire logic [3:0]       be,
    input  wire logic [31:0]      wr_data,
    output logic      [31:0]      rd_word
);

    typedef struct packed {
        logic [WORDS-1:0][31:0] word;
    } pdar_mem_s;

    pdar_mem_s cur;
    pdar_mem_s next_cur;

    // ==========================================================
    // byte-lane write, combinational read
    always_comb
    begin
        next_cur = cur;
        if (wr_en)
        begin
            next_cur.word[idx] = pdar_merge(cur.word[idx], wr_data, be);
        end
    end

    // flip-flop storage costs area but gives a read in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rd_word = cur.word[idx];

endmodule

// ---- logic/pdar_app_regs.sv ----
`timescale 1ns/1ps
module pdar_app_regs
    import pdar_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic                   bar_sel,
    input  wire logic [PDAR_ADDR_W-1:0] addr,
    input  wire logic [PDAR_BE_W-1:0]   be,
    input  wire logic [PDAR_DATA_W-1:0] wr_data,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic      [PDAR_DATA_W-1:0] rd_data,
    input  wire logic [PDAR_DIP_W-1:0]  dip_sw,
    output logic      [PDAR_LED_W-1:0]  led_seg
);

    // ==========================================================
    // state
    typedef struct packed {
        logic                   run;
        logic [PDAR_CNT_W-1:0]  reload;
        logic [PDAR_LED_W-1:0]  led;
        logic [PDAR_DATA_W-1:0] rd_data;
        logic [PDAR_DIP_W-1:0]  dip_meta;
        logic [PDAR_DIP_W-1:0]  dip_sync;
    } pdar_regs_s;

    pdar_regs_s cur;
    pdar_regs_s next_cur;

    logic                  app;
    logic                  mem_hit;
    logic                  start;
    logic [14:0]           mem_off;
    logic [PDAR_IDX_W-1:0] mem_idx;
    logic [PDAR_CNT_W-1:0] count;
    logic [31:0]           mem_word;
    logic                  hit_ctrl;
    logic                  hit_reload;
    logic                  hit_count;
    logic                  hit_dip;
    logic                  hit_led;

    // ==========================================================
    // decode
    function automatic logic reg_hit(
        input logic [14:0] a,
        input logic [14:0] off
    );
        return a[14:2] == off[14:2];
    endfunction

    assign app     = bar_sel == PDAR_BAR_APP;
    assign mem_hit = app && addr >= PDAR_MEM_BASE
                     && addr < PDAR_MEM_END;
    assign mem_off = addr - PDAR_MEM_BASE;
    assign mem_idx = mem_off[PDAR_IDX_LSB +: PDAR_IDX_W];

    // one hit per register for the checks; each already holds app
    assign hit_ctrl   = app && reg_hit(addr, PDAR_OFF_CTRL);
    assign hit_reload = app && reg_hit(addr, PDAR_OFF_RELOAD);
    assign hit_count  = app && reg_hit(addr, PDAR_OFF_COUNT);
    assign hit_dip    = app && reg_hit(addr, PDAR_OFF_DIP);
    assign hit_led    = app && reg_hit(addr, PDAR_OFF_LED);

    // a start only while stopped, so rewriting run=1 does not restart
    assign start = wr_en && app && reg_hit(addr, PDAR_OFF_CTRL)
                   && be[0] && wr_data[PDAR_RUN_BIT] && !cur.run;

    // ==========================================================
    // sub-blocks
    pdar_down_counter #(
        .CNT_W   (PDAR_CNT_W)
    ) u_counter (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .load    (start),
        .run     (cur.run),
        .reload  (cur.reload),
        .count   (count)
    );

    pdar_block_mem #(
        .WORDS   (PDAR_MEM_WORDS),
        .IDX_W   (PDAR_IDX_W)
    ) u_mem (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .wr_en   (wr_en && mem_hit),
        .idx     (mem_idx),
        .be      (be),
        .wr_data (wr_data),
        .rd_word (mem_word)
    );

    // ==========================================================
    // register writes and read mux
    always_comb
    begin
        logic [31:0] led_w;
        led_w = pdar_merge({16'h0000, cur.led}, wr_data, be);
        next_cur = cur;
        next_cur.dip_meta = dip_sw;
        next_cur.dip_sync = cur.dip_meta;
        if (wr_en && app)
        begin
            if (reg_hit(addr, PDAR_OFF_CTRL) && be[0])
            begin
                next_cur.run = wr_data[PDAR_RUN_BIT];
            end
            if (reg_hit(addr, PDAR_OFF_RELOAD))
            begin
                next_cur.reload = pdar_merge(cur.reload, wr_data, be);
            end
            if (reg_hit(addr, PDAR_OFF_LED))
            begin
                next_cur.led = led_w[PDAR_LED_W-1:0];
            end
        end
        // unmapped and other-region reads answer zero
        next_cur.rd_data = '0;
        if (rd_en && app)
        begin
            if (mem_hit)
            begin
                next_cur.rd_data = mem_word;
            end
            else if (reg_hit(addr, PDAR_OFF_CTRL))
            begin
                next_cur.rd_data = {31'h0000_0000, cur.run};
            end
            else if (reg_hit(addr, PDAR_OFF_RELOAD))
            begin
                next_cur.rd_data = cur.reload;
            end
            else if (reg_hit(addr, PDAR_OFF_COUNT))
            begin
                next_cur.rd_data = count;
            end
            else if (reg_hit(addr, PDAR_OFF_DIP))
            begin
                next_cur.rd_data = {24'h00_0000, cur.dip_sync};
            end
            else if (reg_hit(addr, PDAR_OFF_LED))
            begin
                next_cur.rd_data = {16'h0000, cur.led};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur          <= '0;
            cur.reload   <= PDAR_RELOAD_RST;
            cur.led      <= PDAR_LED_RST;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rd_data = cur.rd_data;
    assign led_seg = cur.led;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence start_s;
        start;
    endsequence

    sequence running_s;
        cur.run && !start;
    endsequence

    other_bar_a: assert property (
        (rd_en && !app) |=> rd_data == '0)
        else $error("read outside the application region not zero");

    count_step_a: assert property (
        (running_s and count != '0) |=> count == $past(count) - 1'b1)
        else $error("running counter did not decrement by one");

    start_load_a: assert property (
        start_s |=> (count == $past(cur.reload) && cur.run))
        else $error("start did not load the reload value");

    stop_hold_a: assert property (
        (!cur.run && !start) |=> $stable(count))
        else $error("stopped counter changed");

    zero_reload_a: assert property (
        (running_s and count == '0) |=> count == $past(cur.reload))
        else $error("counter at zero did not reload");

    count_read_a: assert property (
        (rd_en && app && reg_hit(addr, PDAR_OFF_COUNT))
        |=> rd_data == $past(count))
        else $error("count read returned a wrong value");

    dip_read_a: assert property (
        (rd_en && app && reg_hit(addr, PDAR_OFF_DIP))
        |=> rd_data == {24'h00_0000, $past(dip_sw, 3)})
        else $error("switch read does not follow the pins");

    led_write_a: assert property (
        (wr_en && app && reg_hit(addr, PDAR_OFF_LED) && be[1:0] == 2'h3)
        |=> led_seg == $past(wr_data[PDAR_LED_W-1:0]))
        else $error("led word not taken from the write");

    // ==========================================================
    // memory read-back, write and read back to back
    sequence mem_byte_wr_s;
        wr_en && mem_hit && be == 4'h1;
    endsequence

    sequence mem_word_wr_s;
        wr_en && mem_hit && be == 4'hF;
    endsequence

    // the read must follow at once, so no other write slips between
    sequence mem_readback_s;
        rd_en && mem_hit && addr == $past(addr);
    endsequence

    mem_byte_a: assert property (
        mem_byte_wr_s ##1 mem_readback_s
        |=> rd_data[7:0] == $past(wr_data[7:0], 2))
        else $error("memory byte read back wrong");

    mem_word_a: assert property (
        mem_word_wr_s ##1 mem_readback_s
        |=> rd_data == $past(wr_data, 2))
        else $error("memory word read back wrong");

    // ==========================================================
    // register write paths and read mux
    rd_idle_a: assert property (
        !rd_en
        |=> rd_data == '0)
        else $error("read data not zero outside its data cycle");

    run_write_a: assert property (
        (wr_en && hit_ctrl && be[0])
        |=> cur.run == $past(wr_data[PDAR_RUN_BIT]))
        else $error("run bit not taken from the control write");

    run_keep_a: assert property (
        !(wr_en && hit_ctrl && be[0])
        |=> $stable(cur.run))
        else $error("run bit changed without a control write");

    // a second start while running must leave the count alone, so a
    // host that rewrites the whole control word does not upset it
    no_restart_a: assert property (
        (wr_en && hit_ctrl && be[0] && wr_data[PDAR_RUN_BIT]
         && cur.run && count != '0)
        |=> count == $past(count) - 1'b1)
        else $error("control write while running reloaded the count");

    ctrl_read_a: assert property (
        (rd_en && hit_ctrl)
        |=> rd_data == {31'h0000_0000, $past(cur.run)})
        else $error("control read returned a wrong value");

    reload_write_a: assert property (
        (wr_en && hit_reload && be == 4'hF)
        |=> cur.reload == $past(wr_data))
        else $error("reload value not taken from the write");

    reload_lane_a: assert property (
        (wr_en && hit_reload && be == 4'h1)
        |=> cur.reload == {$past(cur.reload[31:8]), $past(wr_data[7:0])})
        else $error("reload low byte write touched other lanes");

    reload_high_a: assert property (
        (wr_en && hit_reload && be == 4'h8)
        |=> cur.reload == {$past(wr_data[31:24]), $past(cur.reload[23:0])})
        else $error("reload top byte write touched other lanes");

    reload_read_a: assert property (
        (rd_en && hit_reload)
        |=> rd_data == $past(cur.reload))
        else $error("reload read returned a wrong value");

    // the reload value must survive counting, stops and starts
    reload_keep_a: assert property (
        !(wr_en && hit_reload)
        |=> $stable(cur.reload))
        else $error("reload value changed without a reload write");

    led_read_a: assert property (
        (rd_en && hit_led)
        |=> rd_data == {16'h0000, $past(led_seg)})
        else $error("led read returned a wrong value");

    led_lane_a: assert property (
        (wr_en && hit_led && be[1:0] == 2'h2)
        |=> led_seg == {$past(wr_data[15:8]), $past(led_seg[7:0])})
        else $error("led upper byte write touched the lower lane");

    led_keep_a: assert property (
        !(wr_en && hit_led)
        |=> $stable(led_seg))
        else $error("led word changed without a led write");

    other_write_a: assert property (
        (wr_en && !app)
        |=> $stable(cur.run) && $stable(cur.reload) && $stable(led_seg))
        else $error("write outside the application region took effect");

    // holes in the map must read as zero, never as a stale register
    unmapped_read_a: assert property (
        (rd_en && app && !mem_hit && !hit_ctrl && !hit_reload
         && !hit_count && !hit_dip && !hit_led)
        |=> rd_data == '0)
        else $error("unmapped read not zero");

endmodule

// ---- tb/pdar_host_model.sv ----
`timescale 1ns/1ps
module pdar_host_model
    import pdar_pkg::*;
(
    input  wire logic                   ref_clk,
    output logic                        bar_sel,
    output logic      [PDAR_ADDR_W-1:0] addr,
    output logic      [PDAR_BE_W-1:0]   be,
    output logic      [PDAR_DATA_W-1:0] wr_data,
    output logic                        wr_en,
    output logic                        rd_en,
    input  wire logic [PDAR_DATA_W-1:0] rd_data
);
    // ==========================================================
    // idle bus
    initial
    begin
        bar_sel = 1'b0;
        addr    = '0;
        be      = '0;
        wr_data = '0;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
    end

    // ==========================================================
    // bus cycles; address and data are inverted once released so a
    // design that latches late sees garbage, not the old value
    task automatic wr(input logic s, input logic [14:0] a,
                      input logic [3:0] b, input logic [31:0] d);
        @(posedge ref_clk);
        bar_sel <= s;
        addr    <= a;
        be      <= b;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        addr    <= ~a;
        wr_data <= ~d;
    endtask

    task automatic rd(input logic s, input logic [14:0] a,
                      output logic [31:0] d);
        @(posedge ref_clk);
        bar_sel <= s;
        addr    <= a;
        rd_en   <= 1'b1;
        @(posedge ref_clk);
        rd_en   <= 1'b0;
        addr    <= ~a;
        #1;
        d = rd_data;
    endtask

    // write then read the same word with no idle cycle between strobes
    task automatic wr_rd(input logic s, input logic [14:0] a,
                         input logic [3:0] b, input logic [31:0] d,
                         output logic [31:0] q);
        @(posedge ref_clk);
        bar_sel <= s;
        addr    <= a;
        be      <= b;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        rd_en   <= 1'b1;
        wr_data <= ~d;
        @(posedge ref_clk);
        rd_en   <= 1'b0;
        addr    <= ~a;
        #1;
        q = rd_data;
    endtask
endmodule

// ---- tb/pdar_app_regs_bench.sv ----
`timescale 1ns/1ps
module pdar_app_regs_bench
    import pdar_pkg::*;
;
    logic        ref_clk;
    logic        rst_b;
    logic        bar_sel;
    logic [14:0] addr;
    logic [3:0]  be;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic [7:0]  dip_sw;
    logic [15:0] led_seg;
    logic [31:0] v;
    logic [31:0] u;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;

    pdar_app_regs pdar_app_regs_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .bar_sel(bar_sel),
        .addr(addr), .be(be), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .dip_sw(dip_sw),
        .led_seg(led_seg)
    );

    pdar_host_model pdar_host_model_inst (
        .ref_clk(ref_clk), .bar_sel(bar_sel), .addr(addr), .be(be),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data)
    );

    // ==========================================================
    // helpers
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    task automatic w(input logic [14:0] a, input logic [3:0] b,
                     input logic [31:0] d, input logic s = 1'b1);
        pdar_host_model_inst.wr(s, a, b, d);
    endtask

    task automatic rc(input string nm, input logic [14:0] a,
                      input logic [31:0] exp, input logic s = 1'b1);
        logic [31:0] d;
        pdar_host_model_inst.rd(s, a, d);
        check(nm, d, exp);
    endtask

    // ==========================================================
    // clock and watchdog
    initial
    begin
        ref_clk = 1'b0;
    end
    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            print_verdict();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rst_b  = 1'b0;
        dip_sw = 8'h00;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++)
            rc("reset value", 15'(4 * i), 32'h0);
        check("led pins", {16'h0, led_seg}, 32'h0);
        @(posedge ref_clk);
        #1;
        check("read data after slot", rd_data, 32'h0);
        w(PDAR_OFF_LED, 4'hF, 32'hFFFF_A5C3);
        #1;
        check("led pins", {16'h0, led_seg}, 32'h0000_A5C3);
        w(PDAR_OFF_LED, 4'h2, 32'h0000_FF00);
        rc("led lane", PDAR_OFF_LED, 32'h0000_FFC3);
        w(PDAR_OFF_LED, 4'hF, 32'h0, 1'b0);
        rc("other region", PDAR_OFF_LED, 32'h0, 1'b0);
        rc("led kept", PDAR_OFF_LED, 32'h0000_FFC3);
        rc("unmapped", 15'h0020, 32'h0);
        // memory: first word, halfword, last word by bytes
        w(PDAR_MEM_BASE, 4'hF, 32'h0302_0100);
        w(PDAR_MEM_BASE, 4'hC, 32'hBEEF_0000);
        rc("mem half", PDAR_MEM_BASE, 32'hBEEF_0100);
        w(PDAR_MEM_BASE, 4'hF, 32'h0, 1'b0);
        rc("mem other wr", PDAR_MEM_BASE, 32'hBEEF_0100);
        for (int i = 0; i < 4; i++)
            w(PDAR_MEM_END - 15'h4, 4'(1 << i), {4{8'hA0 + 8'(i)}});
        rc("mem bytes", PDAR_MEM_END - 15'h4, 32'hA3A2_A1A0);
        // write and read back with no idle cycle between the strobes
        pdar_host_model_inst.wr_rd(1'b1, PDAR_MEM_BASE + 15'h8, 4'h1,
                                   32'h1234_5677, v);
        check("mem byte back", v, 32'h0000_0077);
        pdar_host_model_inst.wr_rd(1'b1, PDAR_MEM_BASE + 15'h8, 4'hF,
                                   32'h1234_5678, v);
        check("mem word back", v, 32'h1234_5678);
        rc("below window", PDAR_MEM_BASE - 15'h4, 32'h0);
        rc("above window", PDAR_MEM_END, 32'h0);
        rc("mem other bar", PDAR_MEM_BASE, 32'h0, 1'b0);
        // switches through the two-flop synchroniser
        @(posedge ref_clk);
        dip_sw <= 8'h5A;
        repeat (4) @(posedge ref_clk);
        rc("switches", PDAR_OFF_DIP, 32'h0000_005A);
        w(PDAR_OFF_DIP, 4'hF, 32'hFFFF_FFFF);
        rc("switches ro", PDAR_OFF_DIP, 32'h0000_005A);
        @(posedge ref_clk);
        dip_sw <= 8'hA5;
        repeat (3) @(posedge ref_clk);
        rc("switches new", PDAR_OFF_DIP, 32'h0000_00A5);
        // counter with reload 3 has period 4
        w(PDAR_OFF_RELOAD, 4'hF, 32'h0000_0003);
        w(PDAR_OFF_CTRL, 4'hF, 32'h0000_0001);
        pdar_host_model_inst.rd(1'b1, PDAR_OFF_COUNT, v);
        pdar_host_model_inst.rd(1'b1, PDAR_OFF_COUNT, u);
        check("count step", u, (v >= 2) ? v - 2 : v + 2);
        repeat (2) @(posedge ref_clk);
        rc("count wrap", PDAR_OFF_COUNT, u);
        w(PDAR_OFF_CTRL, 4'hF, 32'h0);
        pdar_host_model_inst.rd(1'b1, PDAR_OFF_COUNT, v);
        repeat (5) @(posedge ref_clk);
        rc("count held", PDAR_OFF_COUNT, v);
        check("held in range", {31'h0, v <= 32'h3}, 32'h1);
        // restart picks up the newest reload value
        w(PDAR_OFF_RELOAD, 4'hF, 32'hFFFF_FFF0);
        w(PDAR_OFF_CTRL, 4'hF, 32'h0000_0001);
        pdar_host_model_inst.rd(1'b1, PDAR_OFF_COUNT, v);
        check("reload start",
              {31'h0, v <= 32'hFFFF_FFF0 && v > 32'hFFFF_FFE0},
              32'h1);
        // a second start while running must not reload the count
        w(PDAR_OFF_CTRL, 4'hF, 32'h0000_0001);
        pdar_host_model_inst.rd(1'b1, PDAR_OFF_COUNT, u);
        check("no restart", u, v - 32'h4);
        w(PDAR_OFF_RELOAD, 4'h1, 32'h0000_00AB);
        rc("reload lane", PDAR_OFF_RELOAD, 32'hFFFF_FFAB);
        w(PDAR_OFF_RELOAD, 4'h8, 32'h1200_0000);
        rc("reload top", PDAR_OFF_RELOAD, 32'h12FF_FFAB);
        print_verdict();
    end
endmodule
